// ---- irq_ctrl_pkg.sv ----
// package for the interrupt controller: register map, field layout, reset values
// assumes an axi4-lite master with 32-bit data; registers sit in the low byte
`default_nettype none
package irq_ctrl_pkg;
	localparam logic [7:0] enable_offset   = 8'h0c;
	localparam logic [7:0] flags_offset    = 8'h0d;
	localparam logic [7:0] class_offset    = 8'h0e;
	localparam logic [7:0] tick_offset     = 8'h0f;
	localparam logic [7:0] key_offset      = 8'h14;
	localparam logic [7:0] status_offset   = 8'h15;

	localparam int num_slots = 8;
	localparam logic [7:0] src_used_mask   = 8'hbf;
	localparam logic [7:0] enable_reset    = 8'h00;
	localparam logic [7:0] flags_reset     = 8'h00;
	localparam logic [7:0] class_reset     = 8'h00;
	localparam logic [7:0] tick_reset      = 8'h43;
	localparam logic [7:0] key_reset       = 8'h00;
	localparam logic [7:0] tick_write_mask = 8'h7f;
	localparam logic [7:0] key_write_mask  = 8'h20;

	localparam int fast_rate_lsb = 0;
	localparam int slow_rate_lsb = 3;
	localparam int ext_edge_bit  = 6;
	localparam int key_mode_bit  = 5;
	localparam int slow_div_bits = 14;

	localparam logic [10:0] vector_base = 11'h7e0;
	localparam logic [1:0]  axi_okay    = 2'b00;
	localparam logic [1:0]  axi_slverr  = 2'b10;

	// fast tick taps for codes 000..011 (codes 100..111 tap 7 minus the code), slow tick taps are 13 minus the code
	localparam logic [3:0] fast_tap_0 = 4'ha;
	localparam logic [3:0] fast_tap_1 = 4'h8;
	localparam logic [3:0] fast_tap_2 = 4'h6;
	localparam logic [3:0] fast_tap_3 = 4'h4;
	localparam logic [3:0] slow_tap_top = 4'hd;

	typedef struct packed {
		logic timer_two;
		logic timer_one;
		logic timer_zero;
		logic timer_zero_stop;
		logic key_strobe_source;
		logic key_scan_done;
		logic external_pin;
	} event_in_t;

	typedef struct packed {
		logic        irq_req;
		logic        nmi_req;
		logic [10:0] vector;
		logic        wake;
	} core_req_t;

	typedef enum logic [1:0] {
		core_idle    = 2'b00,
		core_service = 2'b01,
		core_return  = 2'b11
	} core_state_t;
endpackage
`default_nettype wire

// ---- irq_ctrl.sv ----
// interrupt controller: seven sources, sticky flags, irq/nmi class, tick taps, vectors
// assumes the core pulses take/return, event inputs are single-cycle pulses in
// the clock domain; the external pin and slow clock arrive asynchronously
`default_nettype none
module irq_ctrl (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire irq_ctrl_pkg::event_in_t  events,
	input  wire logic                     timer_zero_stop_en,
	input  wire logic                     slow_clock,
	input  wire logic                     external_source,
	input  wire logic                     halt_mode,
	input  wire logic                     standby_mode,
	input  wire logic                     key_change,
	input  wire logic                     core_take,
	input  wire logic                     core_return,
	output irq_ctrl_pkg::core_req_t       core_req,
	output logic                          core_busy
);
	logic [7:0] enable_reg, enable_next;
	logic [7:0] flags_reg, flags_next;
	logic [7:0] class_reg, class_next;
	logic [7:0] tick_reg, tick_next;
	logic [7:0] key_reg, key_next;
	localparam int slow_div_width = irq_ctrl_pkg::slow_div_bits;
	logic [2:0] slow_sync_reg;
	logic [2:0] ext_sync_reg;
	logic [slow_div_width-1:0] div_reg, div_next;
	logic [slow_div_width-1:0] div_prev_reg;
	logic [7:0] nmi_prev_reg, nmi_prev_next;
	irq_ctrl_pkg::core_state_t state_reg, state_next;
	irq_ctrl_pkg::core_req_t req_reg, req_next;
	logic busy_next;
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic [7:0] w_data_reg, w_data_next;
	logic w_lane_reg, w_lane_next;
	logic bvalid_next, rvalid_next;
	logic [1:0] bresp_next, rresp_next;
	logic [31:0] rdata_next;
	logic awready_next, wready_next, arready_next;

	// tap selection and edge events
	logic [3:0] fast_tap, slow_tap;
	logic [slow_div_width-1:0] tap_fall;
	logic fast_tick, slow_tick, ext_event, key_event, slow_rise;
	logic [7:0] src_event, pending_on, nmi_level, nmi_edge;
	logic wr_fire;
	logic [7:0] wr_index, rd_index;
	logic [7:0] wbyte;

	always_comb begin
		case (tick_reg[irq_ctrl_pkg::fast_rate_lsb +: 3])
			3'h0: fast_tap = irq_ctrl_pkg::fast_tap_0;
			3'h1: fast_tap = irq_ctrl_pkg::fast_tap_1;
			3'h2: fast_tap = irq_ctrl_pkg::fast_tap_2;
			3'h3: fast_tap = irq_ctrl_pkg::fast_tap_3;
			default: fast_tap = 4'(3'h7 - tick_reg[irq_ctrl_pkg::fast_rate_lsb +: 3]);
		endcase
		slow_tap = irq_ctrl_pkg::slow_tap_top
			- {1'b0, tick_reg[irq_ctrl_pkg::slow_rate_lsb +: 3]};
	end

	// both pins pass two flops; the third stage is edge history only
	pin_sync #(
		.depth (3)
	) slow_sync_inst (
		.clock  (clock),
		.rst_n  (rst_n),
		.pin    (slow_clock),
		.stages (slow_sync_reg)
	);
	pin_sync #(
		.depth (3)
	) ext_sync_inst (
		.clock  (clock),
		.rst_n  (rst_n),
		.pin    (external_source),
		.stages (ext_sync_reg)
	);

	assign slow_rise = slow_sync_reg[1] & ~slow_sync_reg[2];
	// divider only advances on rising slow clock edges; halt freezes it
	assign div_next  = (slow_rise && !halt_mode) ? div_reg + slow_div_width'(1) : div_reg;
	assign tap_fall  = div_prev_reg & ~div_reg;
	assign fast_tick = tap_fall[fast_tap] && !halt_mode;
	assign slow_tick = tap_fall[slow_tap] && !halt_mode;
	assign ext_event = tick_reg[irq_ctrl_pkg::ext_edge_bit]
		? (ext_sync_reg[1] & ~ext_sync_reg[2]) : (~ext_sync_reg[1] & ext_sync_reg[2]);
	assign key_event = key_reg[irq_ctrl_pkg::key_mode_bit]
		? events.key_scan_done : events.key_strobe_source;

	always_comb begin
		src_event    = 8'h00;
		src_event[0] = events.timer_two;
		src_event[1] = events.timer_one;
		src_event[2] = timer_zero_stop_en ? events.timer_zero_stop : events.timer_zero;
		src_event[3] = fast_tick;
		src_event[4] = slow_tick;
		src_event[5] = ext_event;
		src_event[7] = key_event;
	end

	// axi write: address and data taken in either order, response after both
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	// registers sit one per word; a misaligned byte address maps nowhere
	assign wr_index = (aw_addr_reg[1:0] == 2'b00) ? {2'b00, aw_addr_reg[7:2]} : 8'hff;
	assign rd_index = (s_axi_araddr[1:0] == 2'b00) ? {2'b00, s_axi_araddr[7:2]} : 8'hff;
	assign wbyte   = w_data_reg;

	always_comb begin
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		w_lane_next  = w_lane_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata[7:0];
			w_lane_next = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
		end
		bvalid_next  = s_axi_bvalid ? !s_axi_bready : wr_fire;
		// readies stay low for the whole response, not only after it shows
		awready_next = !aw_held_next && !bvalid_next;
		wready_next  = !w_held_next && !bvalid_next;
		bresp_next   = s_axi_bresp;
		if (wr_fire) begin
			case (wr_index)
				irq_ctrl_pkg::enable_offset, irq_ctrl_pkg::flags_offset,
				irq_ctrl_pkg::class_offset, irq_ctrl_pkg::tick_offset,
				irq_ctrl_pkg::key_offset: bresp_next = irq_ctrl_pkg::axi_okay;
				default: bresp_next = irq_ctrl_pkg::axi_slverr;
			endcase
		end
	end

	always_comb begin
		enable_next = enable_reg;
		class_next  = class_reg;
		tick_next   = tick_reg;
		key_next    = key_reg;
		flags_next  = flags_reg;
		if (wr_fire && w_lane_reg) begin
			case (wr_index)
				irq_ctrl_pkg::enable_offset: enable_next = wbyte & irq_ctrl_pkg::src_used_mask;
				irq_ctrl_pkg::class_offset:  class_next  = wbyte & irq_ctrl_pkg::src_used_mask;
				irq_ctrl_pkg::tick_offset:   tick_next   = wbyte & irq_ctrl_pkg::tick_write_mask;
				irq_ctrl_pkg::key_offset:    key_next    = wbyte & irq_ctrl_pkg::key_write_mask;
				irq_ctrl_pkg::flags_offset:  flags_next  = flags_reg & wbyte;
				default: ;
			endcase
		end
		// set wins over a same-cycle clear; enable plays no part here
		flags_next = (flags_next | src_event) & irq_ctrl_pkg::src_used_mask;
	end

	// read channel
	always_comb begin
		rvalid_next  = s_axi_rvalid ? !s_axi_rready : (s_axi_arvalid && s_axi_arready);
		arready_next = !rvalid_next;
		rdata_next   = s_axi_rdata;
		rresp_next   = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			rresp_next = irq_ctrl_pkg::axi_okay;
			rdata_next = 32'h0000_0000;
			case (rd_index)
				irq_ctrl_pkg::enable_offset: rdata_next[7:0] = enable_reg;
				irq_ctrl_pkg::flags_offset:  rdata_next[7:0] = flags_reg;
				irq_ctrl_pkg::class_offset:  rdata_next[7:0] = class_reg;
				irq_ctrl_pkg::tick_offset:   rdata_next[7:0] = tick_reg;
				irq_ctrl_pkg::key_offset:    rdata_next[7:0] = key_reg;
				irq_ctrl_pkg::status_offset: rdata_next[7:0] = {5'h00, state_reg, core_busy};
				default: rresp_next = irq_ctrl_pkg::axi_slverr;
			endcase
		end
	end

	// request generation
	assign pending_on = flags_reg & enable_reg;
	assign nmi_level  = pending_on & class_reg;
	assign nmi_edge   = nmi_level & ~nmi_prev_reg;
	assign nmi_prev_next = nmi_level;

	function automatic logic [2:0] pick(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = irq_ctrl_pkg::num_slots - 1; i >= 0; i--) begin
			if (v[i]) idx = 3'(i); // lowest index wins
		end
		return idx;
	endfunction

	// the core owns pc push/pop; we track service so irq_req stays low until return
	always_comb begin
		state_next = state_reg;
		req_next   = req_reg;
		req_next.nmi_req = 1'b0;
		req_next.wake = standby_mode && ((|pending_on) || key_change);
		case (state_reg)
			irq_ctrl_pkg::core_idle: begin
				if (|nmi_edge) begin
					// only the top coincident nmi is offered; others drop
					req_next.nmi_req = 1'b1;
					req_next.vector  = irq_ctrl_pkg::vector_base + {7'h00, pick(nmi_edge), 1'b0};
				end else begin
					req_next.irq_req = |(pending_on & ~class_reg);
					req_next.vector  = irq_ctrl_pkg::vector_base
						+ {7'h00, pick(pending_on & ~class_reg), 1'b0};
				end
				if (core_take) begin
					// drop the level at once so the core never sees it twice
					state_next       = irq_ctrl_pkg::core_service;
					req_next.irq_req = 1'b0;
				end
			end
			irq_ctrl_pkg::core_service: begin
				req_next.irq_req = 1'b0; // level held, re-offered after return
				if (core_return) state_next = irq_ctrl_pkg::core_return;
			end
			irq_ctrl_pkg::core_return: state_next = irq_ctrl_pkg::core_idle;
			default: state_next = irq_ctrl_pkg::core_idle;
		endcase
		busy_next = state_next != irq_ctrl_pkg::core_idle;
	end

	// software-visible registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			enable_reg <= irq_ctrl_pkg::enable_reset;
			flags_reg  <= irq_ctrl_pkg::flags_reset;
			class_reg  <= irq_ctrl_pkg::class_reset;
			tick_reg   <= irq_ctrl_pkg::tick_reset;
			key_reg    <= irq_ctrl_pkg::key_reset;
		end else begin
			enable_reg <= enable_next;
			flags_reg  <= flags_next;
			class_reg  <= class_next;
			tick_reg   <= tick_next;
			key_reg    <= key_next;
		end
	end

	// slow divider and its one-cycle history for tap edges
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_reg      <= '0;
			div_prev_reg <= '0;
		end else begin
			div_reg      <= div_next;
			div_prev_reg <= div_reg;
		end
	end

	// request path toward the core
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			nmi_prev_reg <= 8'h00;
			state_reg    <= irq_ctrl_pkg::core_idle;
			req_reg      <= '0;
			core_busy    <= 1'b0;
		end else begin
			nmi_prev_reg <= nmi_prev_next;
			state_reg    <= state_next;
			req_reg      <= req_next;
			core_busy    <= busy_next;
		end
	end

	// write channel
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 8'h00;
			w_lane_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= irq_ctrl_pkg::axi_okay;
		end else begin
			aw_held_reg   <= aw_held_next;
			w_held_reg    <= w_held_next;
			aw_addr_reg   <= aw_addr_next;
			w_data_reg    <= w_data_next;
			w_lane_reg    <= w_lane_next;
			s_axi_awready <= awready_next;
			s_axi_wready  <= wready_next;
			s_axi_bvalid  <= bvalid_next;
			s_axi_bresp   <= bresp_next;
		end
	end

	// read channel
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= irq_ctrl_pkg::axi_okay;
			s_axi_rdata   <= 32'h0000_0000;
		end else begin
			s_axi_arready <= arready_next;
			s_axi_rvalid  <= rvalid_next;
			s_axi_rresp   <= rresp_next;
			s_axi_rdata   <= rdata_next;
		end
	end

	assign core_req = req_reg;
endmodule

// shift register for an asynchronous pin: two sync stages, then history
module pin_sync #(
	parameter int depth = 3
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        pin,
	output logic [depth-1:0] stages
);
	logic [depth-1:0] stages_next;
	assign stages_next = {stages[depth-2:0], pin};
	// history starts low, matching the idle pins, so reset makes no false edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stages <= '0;
		end else begin
			stages <= stages_next;
		end
	end
endmodule
`default_nettype wire

// ---- irq_ctrl_monitor.sv ----
// port checker for irq_ctrl: bus answers, requests, vectors
// assumes bind into irq_ctrl, one clock, sync active-low reset
`default_nettype none
module irq_ctrl_monitor (
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic                    s_axi_rvalid,
	input wire logic [31:0]             s_axi_rdata,
	input wire logic                    core_take,
	input wire logic                    standby_mode,
	input wire irq_ctrl_pkg::core_req_t core_req,
	input wire logic                    core_busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
		else $error("read answer late or wide");
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	vector_range_a: assert property (
		core_req.irq_req |-> core_req.vector[10:4] == 7'h7e && !core_req.vector[0]
			&& core_req.vector[3:1] != 3'h6)
		else $error("vector outside table");
	irq_drop_a: assert property (
		core_req.irq_req && core_take |=> !core_req.irq_req)
		else $error("request held after take");
	nmi_pulse_a: assert property (
		core_req.nmi_req |=> !core_req.nmi_req)
		else $error("nmi request longer than one cycle");
	busy_quiet_a: assert property (
		core_busy |-> !core_req.irq_req)
		else $error("request while servicing");
	take_busy_a: assert property (
		core_req.irq_req && core_take |=> core_busy)
		else $error("take did not start service");
	wake_cause_a: assert property (
		core_req.wake |-> $past(standby_mode))
		else $error("wake outside standby");
	irq_taken_c: cover property (core_req.irq_req && core_take);
	nmi_seen_c: cover property (core_req.nmi_req);
	wake_seen_c: cover property (core_req.wake);
endmodule
bind irq_ctrl irq_ctrl_monitor irq_ctrl_monitor_inst (
	.clock         (clock),
	.rst_n         (rst_n),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rdata   (s_axi_rdata),
	.core_take     (core_take),
	.standby_mode  (standby_mode),
	.core_req      (core_req),
	.core_busy     (core_busy)
);
`default_nettype wire

// ---- core_model.sv ----
// processor core stand-in: takes a request, services, returns
// assumes irq_ctrl timing; delay sets how slowly an irq is taken
`default_nettype none
module core_model (
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire irq_ctrl_pkg::core_req_t core_req,
	input wire logic [2:0]              delay,
	output logic                        core_take,
	output logic                        core_return,
	output logic                        took,
	output logic [10:0]                 took_vec
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] st;
	logic [5:0] cnt;
	initial begin
		{core_take, core_return, took} = 3'h0;
	end
	// nmi is a pulse, so its vector is captured on sight, not at take
	always @(posedge clock) begin
		core_take <= 1'h0;
		core_return <= 1'h0;
		took <= 1'h0;
		if (cnt != 6'h0)
			cnt <= cnt - 6'h1;
		if (!rst_n) begin
			st <= 2'h0;
			cnt <= 6'h0;
		end else if (st == 2'h0 && (core_req.irq_req || core_req.nmi_req)) begin
			st <= 2'h1;
			cnt <= core_req.nmi_req ? 6'h0 : {3'h0, delay};
			took_vec <= core_req.vector;
		end else if (st == 2'h1 && cnt == 6'h0) begin
			core_take <= 1'h1;
			took <= 1'h1;
			st <= 2'h2;
			cnt <= 6'h28;
		end else if (st == 2'h2 && cnt == 6'h0) begin
			core_return <= 1'h1;
			st <= 2'h3;
			cnt <= 6'h3;
		end else if (st == 2'h3 && cnt == 6'h0) begin
			st <= 2'h0;
		end
	end
endmodule
`default_nettype wire

// ---- irq_ctrl_test.sv ----
// self-checking bench for irq_ctrl: axi4-lite master, events, core partner
// assumes core_model and the bound irq_ctrl_monitor are compiled alongside
`default_nettype none
module irq_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] a_en = {irq_ctrl_pkg::enable_offset[5:0], 2'h0};
	localparam logic [7:0] a_flg = {irq_ctrl_pkg::flags_offset[5:0], 2'h0};
	localparam logic [7:0] a_cls = {irq_ctrl_pkg::class_offset[5:0], 2'h0};
	localparam logic [7:0] a_tick = {irq_ctrl_pkg::tick_offset[5:0], 2'h0};
	localparam logic [7:0] a_key = {irq_ctrl_pkg::key_offset[5:0], 2'h0};
	localparam logic [7:0] a_st = {irq_ctrl_pkg::status_offset[5:0], 2'h0};
	localparam logic [1:0] ok = irq_ctrl_pkg::axi_okay;
	logic clock = 1'h0;
	logic rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic timer_zero_stop_en, slow_clock, external_source, halt_mode, standby_mode;
	logic key_change, core_take, core_return, core_busy, took;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	irq_ctrl_pkg::event_in_t events;
	irq_ctrl_pkg::core_req_t core_req;
	logic [2:0] delay;
	logic [10:0] took_vec;
	logic [6:0] r;
	logic [33:0] rq[$];
	logic [33:0] bq[$];
	logic [33:0] vq[$];
	int miscompares = 0;
	int samples_checked = 0;
	int ntook = 0;
	int i;
	irq_ctrl irq_ctrl_inst (
		.clock              (clock),
		.rst_n              (rst_n),
		.s_axi_awaddr       (s_axi_awaddr),
		.s_axi_awvalid      (s_axi_awvalid),
		.s_axi_awready      (s_axi_awready),
		.s_axi_wdata        (s_axi_wdata),
		.s_axi_wstrb        (s_axi_wstrb),
		.s_axi_wvalid       (s_axi_wvalid),
		.s_axi_wready       (s_axi_wready),
		.s_axi_bresp        (s_axi_bresp),
		.s_axi_bvalid       (s_axi_bvalid),
		.s_axi_bready       (s_axi_bready),
		.s_axi_araddr       (s_axi_araddr),
		.s_axi_arvalid      (s_axi_arvalid),
		.s_axi_arready      (s_axi_arready),
		.s_axi_rdata        (s_axi_rdata),
		.s_axi_rresp        (s_axi_rresp),
		.s_axi_rvalid       (s_axi_rvalid),
		.s_axi_rready       (s_axi_rready),
		.events             (events),
		.timer_zero_stop_en (timer_zero_stop_en),
		.slow_clock         (slow_clock),
		.external_source    (external_source),
		.halt_mode          (halt_mode),
		.standby_mode       (standby_mode),
		.key_change         (key_change),
		.core_take          (core_take),
		.core_return        (core_return),
		.core_req           (core_req),
		.core_busy          (core_busy)
	);
	core_model core_model_inst (
		.clock       (clock),
		.rst_n       (rst_n),
		.core_req    (core_req),
		.delay       (delay),
		.core_take   (core_take),
		.core_return (core_return),
		.took        (took),
		.took_vec    (took_vec)
	);
	always #5 clock = ~clock;
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		bq.push_back({32'h0, resp});
		forever begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		rq.push_back({resp, 24'h0, d});
		forever begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic fire(input logic [6:0] e);
		@(posedge clock);
		events <= e;
		delay <= 3'($urandom_range(5, 0));
		@(posedge clock);
		events <= 7'h0;
	endtask
	task automatic serve(input logic [7:0] keep);
		int t;
		t = ntook;
		repeat (300) if (ntook == t) @(posedge clock);
		check("taken", {33'h0, ntook != t}, 34'h1);
		rd(a_st, 8'h03, ok);
		wr(a_flg, keep, ok);
		// let the service end so a following event meets an idle core
		repeat (80) if (core_busy) @(posedge clock);
	endtask
	task automatic slow_edges(input int n);
		repeat (n) begin
			repeat (4) @(posedge clock);
			slow_clock <= ~slow_clock;
		end
	endtask
	always @(posedge clock) begin
		if (s_axi_rvalid && s_axi_rready)
			check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			check("resp", {32'h0, s_axi_bresp}, bq.pop_front());
		if (took) begin
			check("vector", {23'h0, took_vec}, vq.pop_front());
			ntook++;
		end
	end
	initial begin
		#400000;
		miscompares++;
		give_verdict();
	end
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
			timer_zero_stop_en, slow_clock, external_source, halt_mode, standby_mode,
			key_change, events, delay, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		void'($urandom(32'hff4001ed));
		repeat (16) @(posedge clock);
		rst_n <= 1'h1;
		repeat (2) @(posedge clock);
		rd(a_en, 8'h00, ok);
		rd(a_flg, 8'h00, ok);
		rd(a_cls, 8'h00, ok);
		rd(a_tick, 8'h43, ok);
		rd(a_key, 8'h00, ok);
		rd(8'h40, 8'h00, irq_ctrl_pkg::axi_slverr);
		wr(8'h40, 8'hff, irq_ctrl_pkg::axi_slverr);
		s_axi_wstrb <= 4'h0;
		wr(a_en, 8'hff, ok);
		s_axi_wstrb <= 4'hf;
		rd(a_en, 8'h00, ok);
		fire(7'h70);
		rd(a_flg, 8'h07, ok);
		wr(a_flg, 8'hff, ok);
		rd(a_flg, 8'h07, ok);
		wr(a_flg, 8'hfd, ok);
		rd(a_flg, 8'h05, ok);
		// random event mixes under both key strobe modes
		for (i = 0; i < 6; i++) begin
			r = 7'($urandom) & 7'h76;
			wr(a_key, {2'h0, i[0], 5'h0}, ok);
			wr(a_flg, 8'h00, ok);
			fire(r);
			rd(a_flg, {i[0] ? r[1] : r[2], 4'h0, r[4], r[5], r[6]}, ok);
		end
		wr(a_flg, 8'h00, ok);
		timer_zero_stop_en <= 1'h1;
		fire(7'h10);
		rd(a_flg, 8'h00, ok);
		fire(7'h08);
		rd(a_flg, 8'h04, ok);
		timer_zero_stop_en <= 1'h0;
		external_source <= 1'h1;
		repeat (6) @(posedge clock);
		rd(a_flg, 8'h24, ok);
		wr(a_tick, 8'h03, ok);
		wr(a_flg, 8'h00, ok);
		external_source <= 1'h0;
		repeat (6) @(posedge clock);
		rd(a_flg, 8'h20, ok);
		wr(a_flg, 8'h00, ok);
		wr(a_en, 8'hbf, ok);
		vq.push_back(34'h7e2);
		vq.push_back(34'h7ee);
		fire(7'h22);
		serve(8'hfd);
		serve(8'h7f);
		wr(a_cls, 8'h01, ok);
		vq.push_back(34'h7e0);
		fire(7'h40);
		serve(8'hfe);
		wr(a_cls, 8'h00, ok);
		standby_mode <= 1'h1;
		key_change <= 1'h1;
		repeat (4) @(posedge clock);
		check("wake", {33'h0, core_req.wake}, 34'h1);
		standby_mode <= 1'h0;
		key_change <= 1'h0;
		wr(a_en, 8'h00, ok);
		wr(a_tick, 8'h47, ok);
		halt_mode <= 1'h1;
		slow_edges(40);
		rd(a_flg, 8'h00, ok);
		halt_mode <= 1'h0;
		slow_edges(40);
		rd(a_flg, 8'h08, ok);
		wr(a_tick, 8'h78, ok);
		wr(a_flg, 8'h00, ok);
		slow_edges(300);
		rd(a_flg, 8'h10, ok);
		give_verdict();
	end
endmodule
`default_nettype wire
